// File: inc/aux_trip_regs.svh
/*
  Register map, field positions, defaults and timing counts for the
  auxiliary trip block. Assumes a 200 MHz APB clock and byte addresses.
*/
`ifndef AUX_TRIP_REGS_SVH
`define AUX_TRIP_REGS_SVH
`define AUX_CTRL_OFF 8'h00
`define AUX_DLY0_OFF 8'h04
`define AUX_DLY1_OFF 8'h08
`define AUX_DLY2_OFF 8'h0c
`define AUX_STAT_OFF 8'h10
`define AUX_TEST_OFF 8'h14
`define AUX_EVT_OFF 8'h18
`define AUX_CNT_OFF 8'h1c
`define AUX_CHUTE_EN_BIT 0
`define AUX_PULLEY_EN_BIT 1
`define AUX_CHUTE_POL_BIT 2
`define AUX_PULLEY_POL_BIT 3
`define AUX_BRG1_EN_BIT 4
`define AUX_CAL_BIT 5
`define AUX_CTRL_RST 6'h00
`define AUX_ALM_MAX 4'ha
`define AUX_ALM_DFLT 4'h1
`define AUX_STOP_MAX 6'h3c
`define AUX_CHUTE_STOP_DFLT 6'h03
`define AUX_PULLEY_STOP_DFLT 6'h05
`define AUX_ALIGN_STOP_DFLT 6'h05
`define AUX_TOGGLES 3'h5
`define AUX_PCT_OVER 32'h73
`define AUX_PCT_UNDER 32'h55
`define AUX_PCT_BASE 32'h64
`define AUX_TICK_NS 1000000000
`define AUX_CLK_NS 5
`endif

// File: inc/aux_pkg.sv
/*
  Types for the auxiliary trip block: test sequencer states and codes.
  Assumes the constants header is included by the design.
*/
package aux_pkg;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_RELAY = 2'b10,
    T_FAULT = 2'b11
  } aux_tstate_type;
  typedef enum logic [2:0] {
    TC_NONE = 3'b000,
    TC_RELAY = 3'b001,
    TC_ALIGN = 3'b010,
    TC_OVER = 3'b011,
    TC_UNDER = 3'b100,
    TC_HOT = 3'b101
  } aux_tcode_type;
endpackage : aux_pkg

// File: rtl/aux_trip.sv
/*
  Auxiliary trip logic: chute and pulley inputs plus simulated head
  alignment, each with alarm and stop delay counters, relays, lamps,
  event log and a test sequencer. APB slave, zero wait states.
  Assumes field inputs are already synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aux_trip_regs.svh"
module aux_trip import aux_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `AUX_TICK_NS / `AUX_CLK_NS
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field and plant
  input wire logic chute_in,
  input wire logic pulley_in,
  input wire logic running,
  input wire logic [15:0] meas_speed,
  // relays, lamps, log
  output logic alarm_relay,
  output logic stop_relay,
  output logic alarm_led_amber,
  output logic stop_led_red,
  output logic [2:0] log_alarm,
  output logic [2:0] log_stop,
  // test injection
  output logic [15:0] speed_sim,
  output logic first_bearing_temp_input_en,
  output logic first_bearing_force_hot,
  output logic head_align_fault
);
  logic [5:0] ctrl_reg;
  logic [2:0][15:0] dly_reg;
  logic [2:0][3:0] acnt_reg;
  logic [2:0][5:0] scnt_reg;
  logic [2:0] alarm_q_reg, stop_q_reg;
  logic [5:0] evt_reg;
  logic [27:0] tick_cnt_reg;
  logic [31:0] prdata_reg;
  aux_tstate_type tst_reg, tst_next;
  aux_tcode_type code_reg;
  logic [2:0] tog_cnt_reg;
  logic toggle_reg, refused_reg, run_q_reg;
  logic alarm_relay_reg, stop_relay_reg;
  // lamp follows alarms only, so relay test toggles never light it
  logic amber_reg;
  logic [2:0] log_alarm_reg, log_stop_reg;
  logic [15:0] speed_sim_reg;
  logic brg_en_reg, brg_hot_reg, align_reg;

  // apb decode
  wire acc = psel & penable;
  wire setup = psel & ~penable;
  wire wr = acc & pwrite;
  wire sel_ctrl = paddr == `AUX_CTRL_OFF;
  wire sel_d0 = paddr == `AUX_DLY0_OFF;
  wire sel_d1 = paddr == `AUX_DLY1_OFF;
  wire sel_d2 = paddr == `AUX_DLY2_OFF;
  wire sel_stat = paddr == `AUX_STAT_OFF;
  wire sel_test = paddr == `AUX_TEST_OFF;
  wire sel_evt = paddr == `AUX_EVT_OFF;
  wire sel_cnt = paddr == `AUX_CNT_OFF;
  wire mapped = sel_ctrl | sel_d0 | sel_d1 | sel_d2 | sel_stat
    | sel_test | sel_evt | sel_cnt;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_reg;

  // clamp written delays into their legal ranges
  wire [3:0] wr_alm = (pwdata[3:0] > `AUX_ALM_MAX) ? `AUX_ALM_MAX
    : pwdata[3:0];
  wire [5:0] wr_stop = (pwdata[13:8] > `AUX_STOP_MAX) ? `AUX_STOP_MAX
    : pwdata[13:8];
  wire [15:0] wr_dly = {2'b00, wr_stop, 4'h0, wr_alm};

  // one-second tick
  wire tick = tick_cnt_reg == 28'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_reg <= 28'h0;
    else if (ce) tick_cnt_reg <= tick ? 28'h0 : tick_cnt_reg + 28'h1;
  end

  // trips: contact high is normal unless polarity inverts it
  wire en0 = ctrl_reg[`AUX_CHUTE_EN_BIT];
  wire en1 = ctrl_reg[`AUX_PULLEY_EN_BIT];
  wire pol0 = ctrl_reg[`AUX_CHUTE_POL_BIT];
  wire pol1 = ctrl_reg[`AUX_PULLEY_POL_BIT];
  wire [2:0] ch_en = {align_reg, en1, en0};
  wire [2:0] trip;
  assign trip[0] = en0 & (pol0 ? chute_in : ~chute_in);
  assign trip[1] = en1 & (pol1 ? pulley_in : ~pulley_in);
  assign trip[2] = align_reg;
  wire [2:0] alarm_lvl, stop_lvl;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      localparam logic [5:0] SDEF = (i == 0) ? `AUX_CHUTE_STOP_DFLT
        : (i == 1) ? `AUX_PULLEY_STOP_DFLT : `AUX_ALIGN_STOP_DFLT;
      wire [3:0] acfg = dly_reg[i][3:0];
      wire [5:0] scfg = dly_reg[i][13:8];
      assign alarm_lvl[i] = trip[i] & (acnt_reg[i] == 4'h0);
      assign stop_lvl[i] = trip[i] & (scnt_reg[i] == 6'h0);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acnt_reg[i] <= `AUX_ALM_DFLT;
          scnt_reg[i] <= SDEF;
        end else if (ce) begin
          if (!ch_en[i]) begin
            acnt_reg[i] <= acfg;
            scnt_reg[i] <= scfg;
          end else if (tick) begin
            if (trip[i]) begin
              if (acnt_reg[i] != 4'h0) acnt_reg[i] <= acnt_reg[i] - 4'h1;
              if (scnt_reg[i] != 6'h0) scnt_reg[i] <= scnt_reg[i] - 6'h1;
            end else begin
              if (acnt_reg[i] < acfg) acnt_reg[i] <= acnt_reg[i] + 4'h1;
              else acnt_reg[i] <= acfg;
              if (scnt_reg[i] < scfg) scnt_reg[i] <= scnt_reg[i] + 6'h1;
              else scnt_reg[i] <= scfg;
            end
          end
        end
      end
    end
  endgenerate

  wire any_alarm = |alarm_lvl;
  wire any_stop = |stop_lvl;
  wire [2:0] alarm_rise = alarm_lvl & ~alarm_q_reg;
  wire [2:0] stop_rise = stop_lvl & ~stop_q_reg;
  // set beats a simultaneous write-one-to-clear
  wire [5:0] evt_clr = (wr && sel_evt) ? pwdata[5:0] : 6'h00;
  wire [5:0] evt_set = {stop_rise, alarm_rise};

  // latched in setup so read data stands through the access cycle
  wire [31:0] rd_mux =
      sel_ctrl ? {26'h0, ctrl_reg}
    : sel_d0 ? {16'h0, dly_reg[0]}
    : sel_d1 ? {16'h0, dly_reg[1]}
    : sel_d2 ? {16'h0, dly_reg[2]}
    : sel_stat ? {20'h0, tst_reg, running, stop_lvl, alarm_lvl, trip}
    : sel_test ? {27'h0, refused_reg, 1'b0, code_reg}
    : sel_evt ? {26'h0, evt_reg}
    : sel_cnt ? {2'h0, scnt_reg, acnt_reg}
    : 32'h0;

  // registers, events, relays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `AUX_CTRL_RST;
      dly_reg[0] <= {2'b00, `AUX_CHUTE_STOP_DFLT, 4'h0, `AUX_ALM_DFLT};
      dly_reg[1] <= {2'b00, `AUX_PULLEY_STOP_DFLT, 4'h0, `AUX_ALM_DFLT};
      dly_reg[2] <= {2'b00, `AUX_ALIGN_STOP_DFLT, 4'h0, `AUX_ALM_DFLT};
      evt_reg <= 6'h00;
      alarm_q_reg <= 3'h0;
      stop_q_reg <= 3'h0;
      log_alarm_reg <= 3'h0;
      log_stop_reg <= 3'h0;
      alarm_relay_reg <= 1'b1;
      stop_relay_reg <= 1'b1;
      amber_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (ce) begin
      if (wr && sel_ctrl) ctrl_reg <= pwdata[5:0];
      if (wr && sel_d0) dly_reg[0] <= wr_dly;
      if (wr && sel_d1) dly_reg[1] <= wr_dly;
      if (wr && sel_d2) dly_reg[2] <= wr_dly;
      evt_reg <= (evt_reg & ~evt_clr) | evt_set;
      alarm_q_reg <= alarm_lvl;
      stop_q_reg <= stop_lvl;
      log_alarm_reg <= alarm_rise;
      log_stop_reg <= stop_rise;
      // energized means healthy; test toggling rides on top of the alarm relay only
      alarm_relay_reg <= ~any_alarm ^ toggle_reg;
      stop_relay_reg <= ~any_stop;
      amber_reg <= any_alarm;
      if (setup) prdata_reg <= rd_mux;
    end
  end

  // test sequencer
  wire [2:0] cmd = pwdata[2:0];
  wire cmd_wr = wr & sel_test & (tst_reg == T_IDLE);
  wire cmd_ok = (cmd >= TC_RELAY) & (cmd <= TC_HOT);
  wire refuse = any_alarm | ~ctrl_reg[`AUX_CAL_BIT] | ~cmd_ok
    | ((cmd != TC_RELAY) & running);
  wire start_edge = running & ~run_q_reg;
  wire relay_done = tick & (tog_cnt_reg == `AUX_TOGGLES);

  always_comb begin
    tst_next = tst_reg;
    case (tst_reg)
      T_IDLE: begin
        if (cmd_wr && !refuse)
          tst_next = (cmd == TC_RELAY && running) ? T_RELAY : T_WAIT;
      end
      T_WAIT: begin
        // no cancel: only a start or a reset leaves the wait
        if (start_edge)
          tst_next = (code_reg == TC_RELAY) ? T_RELAY : T_FAULT;
      end
      T_RELAY: begin
        if (relay_done) tst_next = T_IDLE;
      end
      T_FAULT: begin
        if (!running) tst_next = T_IDLE;
      end
      default: tst_next = T_IDLE;
    endcase
  end

  wire fault = tst_reg == T_FAULT;
  wire [31:0] spd_over = (32'(meas_speed) * `AUX_PCT_OVER) / `AUX_PCT_BASE;
  wire [31:0] spd_under = (32'(meas_speed) * `AUX_PCT_UNDER) / `AUX_PCT_BASE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_reg <= T_IDLE;
      code_reg <= TC_NONE;
      tog_cnt_reg <= 3'h0;
      toggle_reg <= 1'b0;
      refused_reg <= 1'b0;
      run_q_reg <= 1'b0;
    end else if (ce) begin
      tst_reg <= tst_next;
      run_q_reg <= running;
      if (cmd_wr) begin
        refused_reg <= refuse;
        if (!refuse) code_reg <= aux_tcode_type'(cmd);
      end
      if (tst_reg == T_RELAY && tick) begin
        // after the fifth toggle the relay returns to its normal drive
        tog_cnt_reg <= relay_done ? 3'h0 : tog_cnt_reg + 3'h1;
        toggle_reg <= relay_done ? 1'b0 : ~toggle_reg;
      end
      if (tst_next == T_IDLE && tst_reg != T_IDLE) code_reg <= TC_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_sim_reg <= 16'h0;
      brg_en_reg <= 1'b0;
      brg_hot_reg <= 1'b0;
      align_reg <= 1'b0;
    end else if (ce) begin
      speed_sim_reg <= (fault && code_reg == TC_OVER) ? spd_over[15:0]
        : (fault && code_reg == TC_UNDER) ? spd_under[15:0]
        : meas_speed;
      // enable is forced only while the test runs, then falls back
      brg_en_reg <= ctrl_reg[`AUX_BRG1_EN_BIT]
        | (fault && code_reg == TC_HOT);
      brg_hot_reg <= fault && code_reg == TC_HOT;
      align_reg <= fault && code_reg == TC_ALIGN;
    end
  end

  assign alarm_relay = alarm_relay_reg;
  assign stop_relay = stop_relay_reg;
  assign alarm_led_amber = amber_reg;
  assign stop_led_red = ~stop_relay_reg;
  assign log_alarm = log_alarm_reg;
  assign log_stop = log_stop_reg;
  assign speed_sim = speed_sim_reg;
  assign first_bearing_temp_input_en = brg_en_reg;
  assign first_bearing_force_hot = brg_hot_reg;
  assign head_align_fault = align_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // input, polarity, delay channel, relay and test sequencer checks
  chk_chute_ignored: assert property (ce && !en0 |=>
    acnt_reg[0] == $past(dly_reg[0][3:0]))
    else $error("chute not reloaded");
  chk_chute_block: assert property (ce && en0 && !pol0 && !chute_in
    && tick && acnt_reg[0] != 4'h0 |=> acnt_reg[0] == $past(acnt_reg[0])
    - 4'h1) else $error("chute low did not count down");
  chk_pulley_ignored: assert property (ce && !en1 |=>
    acnt_reg[1] == $past(dly_reg[1][3:0])
    && scnt_reg[1] == $past(dly_reg[1][13:8]))
    else $error("pulley not ignored while disabled");
  chk_pulley_normal: assert property (ce && en1 && !pol1 && pulley_in
    && tick && acnt_reg[1] < dly_reg[1][3:0] |=> acnt_reg[1] ==
    $past(acnt_reg[1]) + 4'h1) else $error("pulley high no recount");
  chk_pol_invert: assert property (ce && en1 && pol1 && pulley_in
    && tick && scnt_reg[1] != 6'h0 |=> scnt_reg[1] ==
    $past(scnt_reg[1]) - 6'h1) else $error("inverted polarity missed trip");
  chk_alarm_range: assert property (acnt_reg[0] <= `AUX_ALM_MAX
    && acnt_reg[1] <= `AUX_ALM_MAX) else $error("alarm count out of range");
  chk_stop_range: assert property (scnt_reg[0] <= `AUX_STOP_MAX
    && scnt_reg[1] <= `AUX_STOP_MAX) else $error("stop count out of range");
  chk_stop_together: assert property (ce && tick && trip[1]
    && scnt_reg[1] != 6'h0 |=> scnt_reg[1] == $past(scnt_reg[1]) - 6'h1)
    else $error("stop counter idle while tripped");
  chk_alarm_relay: assert property (ce && $rose(alarm_lvl[0])
    && !toggle_reg |=> !alarm_relay && log_alarm[0] && evt_reg[0])
    else $error("alarm expiry not acted on");
  chk_stop_relay: assert property (ce && $rose(stop_lvl[1]) |=>
    !stop_relay ##1 !log_stop[1]) else $error("stop expiry wrong");
  chk_test_refuse: assert property (ce && cmd_wr && (any_alarm
    || !ctrl_reg[`AUX_CAL_BIT]) |=> tst_reg == T_IDLE && refused_reg)
    else $error("test accepted while refused");
  chk_run_refuse: assert property (ce && cmd_wr && running
    && cmd != TC_RELAY |=> tst_reg == T_IDLE) else $error("test while run");
  chk_toggle_count: assert property (tog_cnt_reg <= `AUX_TOGGLES)
    else $error("too many relay toggles");
  chk_fault_end: assert property (ce && fault && !running |=>
    tst_reg == T_IDLE ##1 !align_reg && !brg_hot_reg)
    else $error("fault test did not end with stop");
  chk_hot_enable: assert property (brg_hot_reg |-> brg_en_reg)
    else $error("hot test without bearing enable");

  // chute channel count-down and recovery, align delay and tick wrap checks
  chk_chute_recount: assert property (ce && en0 && !trip[0] && tick
    && acnt_reg[0] < dly_reg[0][3:0] |=> acnt_reg[0] ==
    $past(acnt_reg[0]) + 4'h1) else $error("chute alarm count stuck");
  chk_chute_stop_cnt: assert property (ce && trip[0] && tick
    && scnt_reg[0] != 6'h0 |=> scnt_reg[0] == $past(scnt_reg[0]) - 6'h1)
    else $error("chute stop count idle");
  chk_stop_recount: assert property (ce && en0 && !trip[0] && tick
    && scnt_reg[0] < dly_reg[0][13:8] |=> scnt_reg[0] ==
    $past(scnt_reg[0]) + 6'h1) else $error("chute stop count stuck");
  chk_align_count: assert property (ce && align_reg && tick
    && acnt_reg[2] != 4'h0 |=> acnt_reg[2] == $past(acnt_reg[2]) - 4'h1)
    else $error("align fault bypassed delay");
  chk_tick_wrap: assert property (ce && tick |=> tick_cnt_reg == 28'h0)
    else $error("tick counter did not wrap");

  // lamp, speed and bearing checks
  chk_amber_lamp: assert property (ce && any_alarm |=> alarm_led_amber)
    else $error("amber lamp off during alarm");
  chk_red_lamp: assert property (ce && any_stop |=> stop_led_red)
    else $error("red lamp off during stop");
  chk_over_speed: assert property (ce && fault
    && code_reg == TC_OVER |=> 32'(speed_sim) ==
    (32'($past(meas_speed)) * `AUX_PCT_OVER) / `AUX_PCT_BASE)
    else $error("over-speed value wrong");
  chk_under_speed: assert property (ce && fault
    && code_reg == TC_UNDER |=> 32'(speed_sim) ==
    (32'($past(meas_speed)) * `AUX_PCT_UNDER) / `AUX_PCT_BASE)
    else $error("under-speed value wrong");
  chk_hot_restore: assert property (ce && !fault
    && !ctrl_reg[`AUX_BRG1_EN_BIT] |=> !first_bearing_temp_input_en)
    else $error("bearing enable not restored");

  // test sequencer checks
  chk_relay_start: assert property (ce && cmd_wr && !refuse
    && cmd == TC_RELAY && running |=> tst_reg == T_RELAY)
    else $error("relay test did not start at once");
  chk_relay_end: assert property (ce && relay_done
    && tst_reg == T_RELAY |=> tst_reg == T_IDLE && !toggle_reg)
    else $error("relay test overran");
  chk_relay_steady: assert property (ce && tst_reg == T_RELAY
    && !tick |=> toggle_reg == $past(toggle_reg))
    else $error("relay toggled off the tick");
  chk_wait_start: assert property (ce && tst_reg == T_WAIT
    && start_edge && code_reg != TC_RELAY |=> tst_reg == T_FAULT)
    else $error("fault test did not start on run");

  cov_relay_test: cover property (tst_reg == T_RELAY ##1 tst_reg == T_IDLE);
  cov_fault_test: cover property (fault ##1 tst_reg == T_IDLE);
  cov_alarm_stop: cover property ($rose(alarm_lvl[0]) ##[1:50]
    $rose(stop_lvl[0]));
  cov_refused: cover property (cmd_wr && refuse);
  cov_pulley_alarm: cover property ($rose(alarm_lvl[1]));
endmodule : aux_trip
`default_nettype wire

// File: tb/aux_plant_model.sv
/*
  plant side of the aux trip block: contact lines, speed and a motor
  starter dropped by the stop relay. assumes bench commands change
  just after a pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module aux_plant_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic chute_cmd,
  input wire logic pulley_cmd,
  input wire logic run_cmd,
  input wire logic [15:0] speed_cmd,
  // relay wiring
  input wire logic stop_relay,
  // field and plant lines
  output logic chute_in,
  output logic pulley_in,
  output logic running,
  output logic [15:0] meas_speed
);
  logic trip_reg;
  // contacts are driven both ways, so never left floating
  assign chute_in = chute_cmd;
  assign pulley_in = pulley_cmd;
  assign meas_speed = speed_cmd;
  // starter stays dropped until the operator releases run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reg <= 1'b0;
      running <= 1'b0;
    end else begin
      trip_reg <= (trip_reg | !stop_relay) & run_cmd;
      running <= run_cmd & !trip_reg & stop_relay;
    end
  end
endmodule : aux_plant_model
`default_nettype wire

// File: tb/aux_trip_delay_relay_test_tb.sv
/*
  bench for the aux trip block: apb tasks, scenario tasks and the
  plant model. assumes a 200 MHz pclk and a shortened tick count.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aux_trip_regs.svh"
module aux_trip_delay_relay_test_tb;
  localparam int TK = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, perr;
  logic chute_cmd = 1'b1;
  logic pulley_cmd = 1'b1;
  logic run_cmd = 1'b0;
  logic [15:0] speed_cmd = 16'h03e8;
  logic chute_in, pulley_in, running, alarm_relay, stop_relay;
  logic amber, red, brg_en, hot, align;
  logic [15:0] meas_speed, speed_sim;
  logic [2:0] log_alarm, log_stop;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #2.5 pclk = ~pclk;

  aux_plant_model plant (.pclk(pclk), .presetn(presetn),
    .chute_cmd(chute_cmd), .pulley_cmd(pulley_cmd), .run_cmd(run_cmd),
    .speed_cmd(speed_cmd), .stop_relay(stop_relay), .chute_in(chute_in),
    .pulley_in(pulley_in), .running(running), .meas_speed(meas_speed));

  aux_trip #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chute_in(chute_in), .pulley_in(pulley_in),
    .running(running), .meas_speed(meas_speed),
    .alarm_relay(alarm_relay), .stop_relay(stop_relay),
    .alarm_led_amber(amber), .stop_led_red(red), .log_alarm(log_alarm),
    .log_stop(log_stop), .speed_sim(speed_sim),
    .first_bearing_temp_input_en(brg_en),
    .first_bearing_force_hot(hot), .head_align_fault(align));

  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  // counts settled cycles until the chosen relay reaches v
  task automatic wait_rel(input logic s, input logic v, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while ((s ? stop_relay : alarm_relay) !== v && n < 400);
  endtask : wait_rel

  task automatic t_reset;
    logic [31:0] x;
    rd(`AUX_CTRL_OFF, x);
    chk_w(x, 32'h00000000);
    rd(`AUX_DLY0_OFF, x);
    chk_w(x, 32'h00000301);
    rd(`AUX_DLY1_OFF, x);
    chk_w(x, 32'h00000501);
    rd(8'h20, x);
    chk_w(x, 32'h00000000);
    chk_b(perr, 1'b1);
    chute_cmd <= 1'b0;
    pulley_cmd <= 1'b0;
    cyc(40);
    chk_b(alarm_relay & stop_relay, 1'b1);
    @(posedge pclk);
    chute_cmd <= 1'b1;
    pulley_cmd <= 1'b1;
  endtask : t_reset

  task automatic t_chute;
    logic [31:0] x;
    int n;
    wr(`AUX_CTRL_OFF, 32'h00000001);
    cyc(30);
    @(posedge pclk);
    chute_cmd <= 1'b0;
    wait_rel(1'b0, 1'b0, n);
    chk_b(n >= 2 && n <= TK + 1, 1'b1);
    chk_b(log_alarm === 3'b001 && amber === 1'b1, 1'b1);
    chk_b(stop_relay, 1'b1);
    wait_rel(1'b1, 1'b0, n);
    chk_w(n, 2 * TK);
    chk_b(log_stop === 3'b001 && red === 1'b1, 1'b1);
    rd(`AUX_EVT_OFF, x);
    chk_w(x & 32'h3f, 32'h09);
    wr(`AUX_EVT_OFF, 32'h0000003f);
    rd(`AUX_EVT_OFF, x);
    chk_w(x & 32'h3f, 32'h00);
    chute_cmd <= 1'b1;
    cyc(3);
    chk_b(alarm_relay & stop_relay, 1'b1);
  endtask : t_chute

  task automatic t_early;
    logic [31:0] x;
    wr(`AUX_DLY0_OFF, 32'h00000503);
    // let both counters climb back to the new settings first
    cyc(60);
    @(posedge pclk);
    chute_cmd <= 1'b0;
    repeat (15) begin
      cyc(1);
      chk_b(alarm_relay, 1'b1);
    end
    @(posedge pclk);
    chute_cmd <= 1'b1;
    cyc(60);
    rd(`AUX_CNT_OFF, x);
    chk_w(x & 32'h0003f00f, 32'h00005003);
  endtask : t_early

  task automatic t_pol;
    logic [31:0] x;
    int n;
    wr(`AUX_DLY1_OFF, 32'h00003f0f);
    rd(`AUX_DLY1_OFF, x);
    chk_w(x, 32'h00003c0a);
    wr(`AUX_DLY1_OFF, 32'h00000500);
    wr(`AUX_CTRL_OFF, 32'h0000000a);
    wait_rel(1'b0, 1'b0, n);
    chk_b(n <= 4 && log_alarm === 3'b010, 1'b1);
    @(posedge pclk);
    pulley_cmd <= 1'b0;
    cyc(3);
    chk_b(alarm_relay, 1'b1);
    wr(`AUX_CTRL_OFF, 32'h00000002);
    wait_rel(1'b0, 1'b0, n);
    chk_b(n <= 4, 1'b1);
  endtask : t_pol

  task automatic t_refuse;
    logic [31:0] x;
    wr(`AUX_CTRL_OFF, 32'h00000022);
    wr(`AUX_TEST_OFF, 32'h00000001);
    rd(`AUX_TEST_OFF, x);
    chk_b(x[4], 1'b1);
    pulley_cmd <= 1'b1;
    wr(`AUX_CTRL_OFF, 32'h00000002);
    wr(`AUX_TEST_OFF, 32'h00000001);
    rd(`AUX_TEST_OFF, x);
    chk_b(x[4], 1'b1);
    wr(`AUX_CTRL_OFF, 32'h00000020);
    run_cmd <= 1'b1;
    wr(`AUX_TEST_OFF, 32'h00000003);
    rd(`AUX_TEST_OFF, x);
    chk_b(x[4], 1'b1);
    rd(`AUX_STAT_OFF, x);
    chk_w(x & 32'hc00, 32'h0);
  endtask : t_refuse

  task automatic t_relay;
    logic [31:0] x;
    logic prev;
    int n, t0, t1;
    n = 0;
    t0 = 0;
    t1 = 0;
    prev = 1'b1;
    wr(`AUX_TEST_OFF, 32'h00000001);
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      if (alarm_relay !== prev) begin
        n++;
        if (n == 1) t0 = i;
        if (n == 2) t1 = i;
        prev = alarm_relay;
      end
    end
    chk_w(n, 6);
    chk_w(t1 - t0, TK);
    chk_b(running & alarm_relay, 1'b1);
    rd(`AUX_STAT_OFF, x);
    chk_w(x & 32'hc00, 32'h0);
  endtask : t_relay

  task automatic t_faults;
    logic [31:0] x;
    logic [2:0] codes [4] = '{3'h3, 3'h4, 3'h5, 3'h2};
    int n;
    run_cmd <= 1'b0;
    cyc(3);
    for (int i = 0; i < 4; i++) begin
      wr(`AUX_TEST_OFF, {29'h0, codes[i]});
      rd(`AUX_STAT_OFF, x);
      chk_w(x & 32'hc00, 32'h400);
      run_cmd <= 1'b1;
      cyc(4);
      case (i)
        0: chk_w(speed_sim, 32'h047e);
        1: chk_w(speed_sim, 32'h0352);
        2: chk_b(brg_en & hot, 1'b1);
        default: begin
          wait_rel(1'b1, 1'b0, n);
          chk_b(align === 1'b1 && log_stop === 3'b100, 1'b1);
        end
      endcase
      @(posedge pclk);
      run_cmd <= 1'b0;
      cyc(6);
      rd(`AUX_STAT_OFF, x);
      chk_w(x & 32'hc00, 32'h0);
      chk_w(speed_sim, 32'h03e8);
      chk_b(brg_en | hot | align | running, 1'b0);
    end
  endtask : t_faults

  // bounded run: a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_chute();
    t_early();
    t_pol();
    t_refuse();
    t_relay();
    t_faults();
    close_out();
  end
endmodule : aux_trip_delay_relay_test_tb
`default_nettype wire
